// ===== cef_pkg.sv
// Package for the execution and flag unit: register map, flag layout,
// operation codes, states and bus carriers.
// Assumes a classic Wishbone master on the same clock as the unit.
package cef_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SRC = 8'h04;
    localparam logic [7:0] OFF_DST = 8'h08;
    localparam logic [7:0] OFF_FLAG = 8'h0C;
    localparam logic [7:0] OFF_SP = 8'h10;
    localparam logic [7:0] OFF_PC = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_WAKE = 8'h1C;
    localparam logic [7:0] OFF_VEC = 8'h20;
    localparam logic [7:0] OFF_STK_HI = 8'h24;
    localparam logic [7:0] OFF_STK_LO = 8'h28;

    // ----------------------------------------
    // Command field positions
    // ----------------------------------------
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_BYTE_BIT = 4;
    localparam int CTRL_SRC_ADDR_BIT = 5;
    localparam int CTRL_DST_ADDR_BIT = 6;

    // ----------------------------------------
    // Flag register layout
    // ----------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_D = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_S = 3;
    localparam int FLAG_B = 4;
    localparam int FLAG_O = 5;
    localparam int FLAG_I = 6;
    localparam int FLAG_U = 7;
    localparam int PRIO_LVL_LSB = 12;
    localparam int PRIO_LVL_W = 3;

    // ----------------------------------------
    // Reset values and constants
    // ----------------------------------------
    localparam logic [15:0] RST_FLAG = 16'h0000;
    localparam logic [15:0] RST_SP = 16'h0000;
    localparam logic [19:0] RST_PC = 20'h00000;
    localparam logic [19:0] RST_VEC = 20'h00000;
    localparam logic [19:0] TRAP_VECTOR_ADDR = 20'hFFFDC;
    localparam logic [15:0] STACK_STEP = 16'h0002;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        NOP_OP = 3'h0,
        SUB_OP = 3'h1,
        AND_TEST_OP = 3'h2,
        XOR_OP = 3'h3,
        SWAP_OP = 3'h4,
        UNDEFINED_TRAP_OP = 3'h5,
        HALT_OP = 3'h6
    } cef_op_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_HALT = 2'b10
    } cef_state_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } cef_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } cef_wb_rsp_t;

endpackage

// ===== cef_exec.sv
// Execution and flag unit for subtract, test, exclusive-OR, exchange,
// undefined-instruction trap and halt, reached over a Wishbone slave.
// Assumes one clock, a synchronous active-low reset and a classic master.
//
// Overview of operation
// [RQ1] Subtract stores destination minus source into the destination.
// [RQ2] Subtract sets overflow when the signed result leaves the sized range.
// [RQ3] Subtract sets carry when no borrow happened, clears it on borrow.
// [RQ4] Subtract, test, exclusive-OR set sign from the sized result top bit.
// [RQ5] Subtract, test, exclusive-OR set zero when the sized result is zero.
// [RQ6] Byte size with address destination zero-extends source, works in 16 bits.
// [RQ7] Byte size with address source uses only its lowest 8 bits.
// [RQ8] Software never names address registers as both operands in byte size.
// [RQ9] Software uses the short subtract format only in byte size.
// [RQ10] Software never picks the same data register twice in short subtract.
// [RQ11] Test ANDs the operands, updates flags only, writes back nothing.
// [RQ12] Trap pushes high part with flags, then low part, loads vector contents.
// [RQ13] The trap is taken regardless of interrupt enable or priority level.
// [RQ14] Trap clears stack-select, interrupt-enable and debug after saving flags.
// [RQ15] Halt stops execution until a wake condition occurs.
// [RQ16] Halt ends only on a higher-priority interrupt acknowledge or reset.
// [RQ17] Exchange swaps source and destination contents.
// [RQ18] Byte exchange into address register: zero-extended source in, low byte out.
// [RQ19] Exclusive-OR stores the bitwise XOR into the destination.
// [RQ20] Flags not affected keep their values; exchange and halt touch none.
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module cef_exec
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire cef_pkg::cef_wb_req_t wb_req,
    output var cef_pkg::cef_wb_rsp_t wb_rsp,
    output logic halted,
    output logic trap_pulse
);
    import cef_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    cef_wb_rsp_t rsp_q;
    cef_state_t state_q;
    logic [15:0] src_q, dst_q, flag_q, sp_q, stk_lo_q;
    logic [19:0] pc_q, vec_q, stk_hi_q;
    logic trap_q;

    logic access, wr_fire, exec_fire, wake_ok;
    cef_op_t op;
    logic byte_size, src_addr, dst_addr, eff_word;
    logic [31:0] wmask, rd_data;
    logic [15:0] op_a, op_b, res, wb_val;
    logic res_msb, res_zero, res_ovf, res_carry, sa, sb;
    logic [19:0] ret_pc;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign access = wb_req.cyc && wb_req.stb && !rsp_q.ack;
    assign wr_fire = access && wb_req.we;
    assign op = cef_op_t'(wb_req.dat[CTRL_OP_LSB +: 3]);
    assign byte_size = wb_req.dat[CTRL_BYTE_BIT];
    assign src_addr = wb_req.dat[CTRL_SRC_ADDR_BIT];
    assign dst_addr = wb_req.dat[CTRL_DST_ADDR_BIT];
    assign exec_fire = wr_fire && wb_req.adr == OFF_CTRL && state_q == ST_RUN; // RQ15
    assign wake_ok = wr_fire && wb_req.adr == OFF_WAKE
        && wb_req.dat[PRIO_LVL_W-1:0] > flag_q[PRIO_LVL_LSB +: PRIO_LVL_W]; // RQ16
    assign ret_pc = 20'(pc_q + 20'h00001);
    assign wmask = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}}, {8{wb_req.sel[1]}},
        {8{wb_req.sel[0]}}};

    // ----------------------------------------
    // Operand forming and result
    // ----------------------------------------
    always_comb
    begin
        eff_word = !byte_size || dst_addr; // RQ6
        op_b = byte_size ? {8'h00, src_q[7:0]} : src_q; // RQ7
        op_a = (byte_size && !dst_addr) ? {8'h00, dst_q[7:0]} : dst_q;
        unique case (op)
            SUB_OP: res = 16'(op_a - op_b); // RQ1
            AND_TEST_OP: res = op_a & op_b; // RQ11
            XOR_OP: res = op_a ^ op_b; // RQ19
            default: res = 16'h0000;
        endcase
        res_msb = eff_word ? res[15] : res[7]; // RQ4
        res_zero = eff_word ? (res == 16'h0000) : (res[7:0] == 8'h00); // RQ5
        sa = eff_word ? op_a[15] : op_a[7];
        sb = eff_word ? op_b[15] : op_b[7];
        res_ovf = (sa != sb) && (res_msb != sa); // RQ2
        res_carry = op_a >= op_b; // RQ3
        wb_val = eff_word ? res : {dst_q[15:8], res[7:0]};
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb
    begin
        unique case (wb_req.adr)
            OFF_SRC: rd_data = {16'h0000, src_q};
            OFF_DST: rd_data = {16'h0000, dst_q};
            OFF_FLAG: rd_data = {16'h0000, flag_q};
            OFF_SP: rd_data = {16'h0000, sp_q};
            OFF_PC: rd_data = {12'h000, pc_q};
            OFF_STATUS: rd_data = {31'h00000000, state_q == ST_HALT};
            OFF_VEC: rd_data = {12'h000, vec_q};
            OFF_STK_HI: rd_data = {12'h000, stk_hi_q};
            OFF_STK_LO: rd_data = {16'h0000, stk_lo_q};
            default: rd_data = 32'h00000000;
        endcase
    end

    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rsp_q <= '0;
        end
        else
        begin
            rsp_q.ack <= access;
            if (access && !wb_req.we)
            begin
                rsp_q.dat <= rd_data;
            end
        end
    end

    // ----------------------------------------
    // Operand registers
    // ----------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            src_q <= 16'h0000;
            dst_q <= 16'h0000;
        end
        else if (exec_fire)
        begin
            if (op == SUB_OP || op == XOR_OP)
            begin
                dst_q <= wb_val; // RQ1 RQ19
            end
            else if (op == SWAP_OP)
            begin
                if (!byte_size)
                begin
                    dst_q <= src_q; // RQ17
                    src_q <= dst_q;
                end
                else if (dst_addr)
                begin
                    dst_q <= {8'h00, src_q[7:0]}; // RQ18
                    src_q <= {src_q[15:8], dst_q[7:0]};
                end
                else
                begin
                    dst_q <= {dst_q[15:8], src_q[7:0]}; // RQ17
                    src_q <= {src_q[15:8], dst_q[7:0]};
                end
            end
        end
        else if (wr_fire && wb_req.adr == OFF_SRC)
        begin
            src_q <= (src_q & ~wmask[15:0]) | (wb_req.dat[15:0] & wmask[15:0]);
        end
        else if (wr_fire && wb_req.adr == OFF_DST)
        begin
            dst_q <= (dst_q & ~wmask[15:0]) | (wb_req.dat[15:0] & wmask[15:0]);
        end
    end

    // ----------------------------------------
    // Flag register
    // ----------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            flag_q <= RST_FLAG;
        end
        else if (exec_fire)
        begin
            unique case (op)
                SUB_OP:
                begin
                    flag_q[FLAG_O] <= res_ovf; // RQ2
                    flag_q[FLAG_C] <= res_carry; // RQ3
                    flag_q[FLAG_S] <= res_msb; // RQ4
                    flag_q[FLAG_Z] <= res_zero; // RQ5
                end
                AND_TEST_OP, XOR_OP:
                begin
                    flag_q[FLAG_S] <= res_msb; // RQ4
                    flag_q[FLAG_Z] <= res_zero; // RQ5
                end
                UNDEFINED_TRAP_OP:
                begin
                    flag_q[FLAG_U] <= 1'b0; // RQ14
                    flag_q[FLAG_I] <= 1'b0;
                    flag_q[FLAG_D] <= 1'b0;
                end
                default:
                begin
                    flag_q <= flag_q; // RQ20
                end
            endcase
        end
        else if (wr_fire && wb_req.adr == OFF_FLAG)
        begin
            flag_q <= (flag_q & ~wmask[15:0]) | (wb_req.dat[15:0] & wmask[15:0]);
        end
    end

    // ----------------------------------------
    // Stack, program counter and vector
    // ----------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            sp_q <= RST_SP;
            pc_q <= RST_PC;
            stk_hi_q <= 20'h00000;
            stk_lo_q <= 16'h0000;
        end
        else if (exec_fire && op == UNDEFINED_TRAP_OP)
        begin
            // Taken with no look at the enable flag or the level. RQ13
            stk_hi_q <= {ret_pc[19:16], flag_q}; // RQ12
            stk_lo_q <= ret_pc[15:0]; // RQ12
            sp_q <= 16'(sp_q - STACK_STEP - STACK_STEP); // RQ12
            pc_q <= vec_q; // RQ12
        end
        else if (wr_fire && wb_req.adr == OFF_SP)
        begin
            sp_q <= (sp_q & ~wmask[15:0]) | (wb_req.dat[15:0] & wmask[15:0]);
        end
        else if (wr_fire && wb_req.adr == OFF_PC)
        begin
            pc_q <= (pc_q & ~wmask[19:0]) | (wb_req.dat[19:0] & wmask[19:0]);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            vec_q <= RST_VEC;
        end
        else if (wr_fire && wb_req.adr == OFF_VEC)
        begin
            vec_q <= (vec_q & ~wmask[19:0]) | (wb_req.dat[19:0] & wmask[19:0]);
        end
    end

    // ----------------------------------------
    // Run and halt
    // ----------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state_q <= ST_RUN; // RQ16
        end
        else
        begin
            unique case (state_q)
                ST_RUN:
                begin
                    if (exec_fire && op == HALT_OP)
                    begin
                        state_q <= ST_HALT; // RQ15
                    end
                end
                ST_HALT:
                begin
                    if (wake_ok)
                    begin
                        state_q <= ST_RUN; // RQ16
                    end
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            trap_q <= 1'b0;
        end
        else
        begin
            trap_q <= exec_fire && op == UNDEFINED_TRAP_OP;
        end
    end

    assign wb_rsp = rsp_q;
    assign halted = state_q == ST_HALT;
    assign trap_pulse = trap_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_sub_word_result: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ1
        (exec_fire && op == SUB_OP && !byte_size)
        |=> dst_q == 16'($past(dst_q) - $past(src_q)))
        else $error("Word subtract result wrong.");

    chk_sub_carry_borrow: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ3
        (exec_fire && op == SUB_OP)
        |=> flag_q[FLAG_C] == ($past(op_a) >= $past(op_b)))
        else $error("Carry does not follow borrow.");

    chk_byte_overflow: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ2
        (exec_fire && op == SUB_OP && byte_size && !dst_addr
        && src_q[7:0] == 8'h01 && dst_q[7:0] == 8'h80)
        |=> flag_q[FLAG_O] && !flag_q[FLAG_S])
        else $error("Byte overflow not reported.");

    chk_test_no_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ11
        (exec_fire && op == AND_TEST_OP)
        |=> $stable(dst_q) && $stable(src_q) && flag_q[FLAG_Z] == $past(res_zero))
        else $error("Test changed an operand or missed zero.");

    chk_byte_src_low: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ7
        (exec_fire && op == XOR_OP && byte_size && !dst_addr)
        |=> dst_q[15:8] == $past(dst_q[15:8])
        && dst_q[7:0] == ($past(dst_q[7:0]) ^ $past(src_q[7:0])))
        else $error("Byte exclusive-OR touched the high byte.");

    chk_trap_stack: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ12
        (exec_fire && op == UNDEFINED_TRAP_OP)
        |=> sp_q == 16'($past(sp_q) - 16'h0004) && pc_q == $past(vec_q)
        && stk_hi_q[15:0] == $past(flag_q) && trap_pulse)
        else $error("Trap stacking or vector load wrong.");

    chk_trap_clear_flags: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ14
        (exec_fire && op == UNDEFINED_TRAP_OP)
        |=> !flag_q[FLAG_U] && !flag_q[FLAG_I] && !flag_q[FLAG_D]
        && flag_q[FLAG_C] == $past(flag_q[FLAG_C]))
        else $error("Trap flag clearing wrong.");

    chk_swap_keep_flags: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ20
        (exec_fire && (op == SWAP_OP || op == HALT_OP))
        |=> $stable(flag_q))
        else $error("Exchange or halt altered flags.");

    chk_halt_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ15
        (halted && !wake_ok) |=> halted && $stable(dst_q))
        else $error("Halt left without wake.");

    chk_bus_ack_once: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wb_rsp.ack |=> !wb_rsp.ack)
        else $error("Acknowledge held too long.");

endmodule

`default_nettype wire

// ===== cpu_exec_flags_subset_tb.sv
// Self-checking bench for the execution and flag unit.
// Assumes a Wishbone slave that acks one cycle after taking a request.
`timescale 1ns/1ps
`default_nettype none

module cpu_exec_flags_subset_tb;
    import cef_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] src;
        logic [15:0] dst;
        logic [15:0] exp_dst;
        logic [15:0] exp_src;
        logic [15:0] src_mask;
        logic [15:0] exp_flag;
    } cef_case_t;

    logic sys_clk;
    logic rst_n;
    cef_wb_req_t wb_req;
    cef_wb_rsp_t wb_rsp;
    logic halted;
    logic trap_pulse;
    int fails = 0;
    int n_tests = 0;
    int pulse_cnt = 0;
    logic [31:0] rd;

    // ----------------------------------------
    // Operation table, flags preset to 16'h303F
    // ----------------------------------------
    cef_case_t tbl [13] = '{
        '{8'h01, 16'h0001, 16'h8000, 16'h7FFF, 16'h0001, 16'hFFFF, 16'h3033},
        '{8'h01, 16'h0002, 16'h0001, 16'hFFFF, 16'h0002, 16'hFFFF, 16'h301A},
        '{8'h11, 16'h0001, 16'h1280, 16'h127F, 16'h0001, 16'hFFFF, 16'h3033},
        '{8'h11, 16'h0055, 16'h0055, 16'h0000, 16'h0055, 16'hFFFF, 16'h3017},
        '{8'h51, 16'hFF02, 16'h0100, 16'h00FE, 16'hFF02, 16'hFFFF, 16'h3013},
        '{8'h31, 16'h1234, 16'h0050, 16'h001C, 16'h1234, 16'hFFFF, 16'h3013},
        '{8'h02, 16'h8001, 16'h8000, 16'h8000, 16'h8001, 16'hFFFF, 16'h303B},
        '{8'h12, 16'h000F, 16'h00F0, 16'h00F0, 16'h000F, 16'hFFFF, 16'h3037},
        '{8'h03, 16'hA5A5, 16'hA5A5, 16'h0000, 16'hA5A5, 16'hFFFF, 16'h3037},
        '{8'h53, 16'h0001, 16'h8001, 16'h8000, 16'h0001, 16'hFFFF, 16'h303B},
        '{8'h04, 16'h1111, 16'h2222, 16'h1111, 16'h2222, 16'hFFFF, 16'h303F},
        '{8'h54, 16'hAB77, 16'h1234, 16'h0077, 16'h0034, 16'h00FF, 16'h303F},
        '{8'h33, 16'h12F0, 16'hAB0F, 16'hABFF, 16'h12F0, 16'hFFFF, 16'h303B}
    };

    cef_exec DUT
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .wb_req(wb_req),
        .wb_rsp(wb_rsp),
        .halted(halted),
        .trap_pulse(trap_pulse)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        if (trap_pulse === 1'b1)
        begin
            pulse_cnt <= pulse_cnt + 1;
        end
    end

    // ----------------------------------------
    // Compare, bus and closing tasks
    // ----------------------------------------
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
        input logic [3:0] sel);
        int i;
        @(posedge sys_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
        for (i = 0; i < 20; i++)
        begin
            @(posedge sys_clk);
            if (wb_rsp.ack === 1'b1)
            begin
                break;
            end
        end
        rd = wb_rsp.dat;
        wb_req <= '0;
        if (i == 20)
        begin
            chk1(wb_rsp.ack, 1'b1);
            results();
        end
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        wb_xfer(1'b1, adr, dat, 4'hF);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        wb_xfer(1'b0, adr, 32'h0000_0000, 4'hF);
        chk32(rd, exp);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        int k;
        rst_n = 1'b0;
        wb_req = '0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd_chk(OFF_FLAG, 32'h0000_0000);
        rd_chk(OFF_SP, 32'h0000_0000);
        rd_chk(OFF_STATUS, 32'h0000_0000);
        wr(8'h40, 32'h0000_FFFF);
        rd_chk(8'h40, 32'h0000_0000);
        for (k = 0; k < 13; k++)
        begin
            wr(OFF_FLAG, 32'h0000_303F);
            wr(OFF_SRC, {16'h0000, tbl[k].src});
            wr(OFF_DST, {16'h0000, tbl[k].dst});
            wr(OFF_CTRL, {24'h000000, tbl[k].ctrl});
            rd_chk(OFF_DST, {16'h0000, tbl[k].exp_dst});
            wb_xfer(1'b0, OFF_SRC, 32'h0000_0000, 4'hF);
            chk32(rd & {16'h0000, tbl[k].src_mask}, {16'h0000, tbl[k].exp_src});
            rd_chk(OFF_FLAG, {16'h0000, tbl[k].exp_flag});
        end
        wr(OFF_FLAG, 32'h0000_70C3);
        wr(OFF_SP, 32'h0000_0100);
        wr(OFF_PC, 32'h0001_2345);
        wr(OFF_VEC, 32'h0000_ABCD);
        chk32(pulse_cnt, 32'h0000_0000);
        wr(OFF_CTRL, 32'h0000_0005);
        rd_chk(OFF_SP, 32'h0000_00FC);
        rd_chk(OFF_STK_HI, 32'h0001_70C3);
        rd_chk(OFF_STK_LO, 32'h0000_2346);
        rd_chk(OFF_PC, 32'h0000_ABCD);
        rd_chk(OFF_FLAG, 32'h0000_7001);
        chk32(pulse_cnt, 32'h0000_0001);
        wr(OFF_FLAG, 32'h0000_303F);
        wr(OFF_DST, 32'h0000_0005);
        wr(OFF_SRC, 32'h0000_0001);
        wr(OFF_CTRL, 32'h0000_0006);
        chk1(halted, 1'b1);
        rd_chk(OFF_STATUS, 32'h0000_0001);
        wr(OFF_CTRL, 32'h0000_0001);
        rd_chk(OFF_DST, 32'h0000_0005);
        rd_chk(OFF_FLAG, 32'h0000_303F);
        wr(OFF_WAKE, 32'h0000_0003);
        chk1(halted, 1'b1);
        wr(OFF_WAKE, 32'h0000_0004);
        chk1(halted, 1'b0);
        wr(OFF_CTRL, 32'h0000_0001);
        rd_chk(OFF_DST, 32'h0000_0004);
        wr(OFF_CTRL, 32'h0000_0006);
        chk1(halted, 1'b1);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        chk1(halted, 1'b0);
        rd_chk(OFF_FLAG, 32'h0000_0000);
        wb_xfer(1'b1, OFF_DST, 32'h0000_FFFF, 4'h1);
        rd_chk(OFF_DST, 32'h0000_00FF);
        results();
    end
endmodule
`default_nettype wire
